// ==== src/msd_params.svh ====
// Address map, bit-area layout and bus timing constants of the memory space decoder.
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH

`define MSD_INT_PROG_TOP   16'h3fff
`define MSD_DIRECT_RAM_TOP 8'h7f
`define MSD_AUX_TOP        16'h00ff
`define MSD_BIT_AREA_HI    4'h2
`define MSD_BIT_SFR_LOW    3'h0
`define MSD_BANK_PTR_PAD   3'h0
`define MSD_BANK_PTR_MID   2'h0
`define MSD_STROBE_CYCLES  3'h3
`define MSD_CNT_ZERO       3'h0
`define MSD_CNT_ONE        3'h1
`define MSD_BYTE_ZERO      8'h00
`define MSD_WORD_ZERO      16'h0000

`endif

// ==== src/msd_pkg.sv ====
// Types shared by the memory space decoder and its external bus sequencer.
package msd_pkg;

  typedef enum logic [2:0] {
    ACC_DIRECT, ACC_INDIRECT, ACC_BIT, ACC_STACK, ACC_XMOVE_IDX, ACC_XMOVE_PTR
  } msd_mode_t;

  typedef enum logic [2:0] {
    SPACE_NONE, SPACE_MAIN_RAM, SPACE_SPECIAL, SPACE_AUX_RAM, SPACE_EXT_DATA
  } msd_space_t;

  typedef enum {ST_IDLE, ST_SFR, ST_EXT} msd_state_t;

  typedef enum {BUS_IDLE, BUS_ADDR, BUS_STROBE} msd_bus_state_t;

  typedef enum logic [1:0] {BUS_FETCH, BUS_READ, BUS_WRITE} msd_bus_kind_t;

  typedef struct packed {
    logic        valid;
    logic        codeRead;
    logic [15:0] addr;
  } msd_fetch_req_t;

  typedef struct packed {
    logic        valid;
    logic        internal;
    logic        blocked;
    logic [15:0] addr;
    logic [7:0]  extData;
  } msd_fetch_rsp_t;

  typedef struct packed {
    logic        valid;
    msd_mode_t   mode;
    logic        write;
    logic        idxSel;
    logic [7:0]  addr;
    logic [15:0] dataPointer;
    logic [7:0]  wdata;
    logic        wbit;
  } msd_data_req_t;

  typedef struct packed {
    logic       valid;
    msd_space_t space;
    logic [7:0] rdata;
    logic       rbit;
  } msd_data_rsp_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       bitOp;
    logic [7:0] addr;
    logic [2:0] bitIdx;
    logic [7:0] wdata;
    logic       wbit;
  } msd_sfr_req_t;

  typedef struct packed {
    logic          valid;
    msd_bus_kind_t kind;
    logic [15:0]   addr;
    logic [7:0]    wdata;
  } msd_bus_req_t;

  typedef struct packed {
    logic [7:0] lowOut;
    logic       lowOe;
    logic [7:0] highOut;
    logic       highOe;
    logic       addrLatch;
    logic       wrStrobe_n;
    logic       rdStrobe_n;
    logic       progStrobe_n;
  } msd_pins_t;

endpackage : msd_pkg

// ==== src/msd_ext_bus.sv ====
// External bus sequencer: address phase, latch pulse and strobe phase on the expansion ports.
`timescale 1ns/1ps
`default_nettype none
`include "msd_params.svh"

module msd_ext_bus
  import msd_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Request from the decoder
  input  wire msd_bus_req_t req,
  output logic              done,
  output logic [7:0]        rdata,
  // Expansion pins
  input  wire logic [7:0]   lowPortIn,
  output msd_pins_t         pins
);

  msd_bus_state_t state;
  msd_bus_kind_t  kindReg;
  logic [2:0]     cntReg;
  logic [7:0]     wdataReg;

  wire logic lastStrobe = (state == BUS_STROBE) && (cntReg == `MSD_CNT_ZERO);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= BUS_IDLE;
      kindReg  <= BUS_READ;
      cntReg   <= `MSD_CNT_ZERO;
      wdataReg <= `MSD_BYTE_ZERO;
      done     <= 1'b0;
      rdata    <= `MSD_BYTE_ZERO;
      pins     <= '{lowOut: `MSD_BYTE_ZERO, lowOe: 1'b0, highOut: `MSD_BYTE_ZERO, highOe: 1'b0,
                    addrLatch: 1'b0, wrStrobe_n: 1'b1, rdStrobe_n: 1'b1, progStrobe_n: 1'b1};
    end else begin
      done <= 1'b0;
      unique case (state)
        BUS_IDLE: begin
          // RULE_13: Address on ports.
          if (req.valid) begin
            kindReg        <= req.kind;
            wdataReg       <= req.wdata;
            pins.lowOut    <= req.addr[7:0];
            pins.lowOe     <= 1'b1;
            pins.highOut   <= req.addr[15:8];
            pins.highOe    <= 1'b1;
            pins.addrLatch <= 1'b1;
            state          <= BUS_ADDR;
          end
        end
        BUS_ADDR: begin
          // RULE_13: Dedicated strobe asserted.
          pins.addrLatch    <= 1'b0;
          pins.lowOut       <= wdataReg;
          pins.lowOe        <= (kindReg == BUS_WRITE);
          pins.wrStrobe_n   <= !(kindReg == BUS_WRITE);
          pins.rdStrobe_n   <= !(kindReg == BUS_READ);
          pins.progStrobe_n <= !(kindReg == BUS_FETCH);
          cntReg            <= `MSD_STROBE_CYCLES - `MSD_CNT_ONE;
          state             <= BUS_STROBE;
        end
        BUS_STROBE: begin
          cntReg <= cntReg - `MSD_CNT_ONE;
          if (lastStrobe) begin
            rdata             <= lowPortIn;
            done              <= 1'b1;
            pins.lowOe        <= 1'b0;
            pins.highOe       <= 1'b0;
            pins.wrStrobe_n   <= 1'b1;
            pins.rdStrobe_n   <= 1'b1;
            pins.progStrobe_n <= 1'b1;
            state             <= BUS_IDLE;
          end
        end
      endcase
    end
  end

endmodule // msd_ext_bus

`default_nettype wire

// ==== src/memory_space_decoder.sv ====
// Memory space decoder: program fetch steering, internal data spaces and external data bus.
//
// Notes on behaviour
// RULE_01: Pin latched high: fetch 0000-3FFF internally, 4000-FFFF externally.
// RULE_02: Pin latched low: every fetch from address zero goes external.
// RULE_03: Access-select pin sampled only during reset, then held and ignored.
// RULE_04: Code reads issued from external code never switch to internal memory while the security bit is set.
// RULE_05: Security bit set protects internal code; clear leaves code reads unrestricted.
// RULE_06: Main RAM 0-127 direct or indirect; 128-255 only indirect via index registers or the stack pointer.
// RULE_07: Direct addresses 128-255 select the special register space.
// RULE_08: Auxiliary RAM reached only by external moves through index registers or pointer.
// RULE_09: Auxiliary RAM accesses leave expansion ports and strobes untouched.
// RULE_10: Lowest 32 bytes hold four 8-byte banks, exactly one active.
// RULE_11: Bytes 32-47 also form 128 individually addressable bits.
// RULE_12: Stack may sit anywhere in main RAM.
// RULE_13: Pointer moves above 255 use both ports and the write or read strobe.
// RULE_14: Index-register external moves never reach locations above 255.
// RULE_15: Lowest 256 external data bytes are served by auxiliary RAM.
`timescale 1ns/1ps
`default_nettype none
`include "msd_params.svh"

module memory_space_decoder
  import msd_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Straps and protection
  input  wire logic           accessSourceSelect,
  input  wire logic           securityBit,
  // Core state
  input  wire logic [1:0]     bankSel,
  input  wire logic [7:0]     stackPointer,
  // Instruction fetch channel
  input  wire msd_fetch_req_t fetchReq,
  output logic                fetchReady,
  output msd_fetch_rsp_t      fetchRsp,
  // Data channel
  input  wire msd_data_req_t  dataReq,
  output logic                dataReady,
  output msd_data_rsp_t       dataRsp,
  // Special register space
  output msd_sfr_req_t        sfrReq,
  input  wire logic [7:0]     sfrRdata,
  // Expansion pins
  input  wire logic [7:0]     lowPortIn,
  output msd_pins_t           busPins
);

  logic [7:0] mainRam [256];
  logic [7:0] auxRam  [256];

  msd_state_t     state;
  msd_state_t     stateNext;
  logic           strapLatchedReg;
  logic           execIntReg;
  logic           extIsFetchReg;
  logic           extCodeReadReg;
  logic [15:0]    extAddrReg;
  logic           sfrBitReg;
  logic [2:0]     sfrBitIdxReg;
  msd_bus_req_t   busReq;
  logic           busDone;
  logic [7:0]     busRdata;

  // Bank base plus index register number gives the pointer's own RAM location.
  function automatic logic [7:0] bank_ptr_addr(input logic [1:0] bank, input logic idx);
    bank_ptr_addr = {`MSD_BANK_PTR_PAD, bank, `MSD_BANK_PTR_MID, idx};
  endfunction

  function automatic logic [7:0] bit_byte_addr(input logic [7:0] bitAddr);
    bit_byte_addr = bitAddr[7] ? {bitAddr[7:3], `MSD_BIT_SFR_LOW}
                               : {`MSD_BIT_AREA_HI, bitAddr[6:3]};
  endfunction

  function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] i,
                                         input logic v);
    logic [7:0] r;
    r    = b;
    r[i] = v;
    set_bit = r;
  endfunction

  wire logic idle = (state == ST_IDLE);

  // RULE_10: Active bank pointer.
  wire logic [7:0] ptrAddr = mainRam[bank_ptr_addr(bankSel, dataReq.idxSel)];

  // RULE_11: Bit area decode.
  wire logic [7:0] bitByte   = bit_byte_addr(dataReq.addr);
  wire logic       directLow = (dataReq.addr <= `MSD_DIRECT_RAM_TOP);
  wire logic       auxWindow = (dataReq.dataPointer <= `MSD_AUX_TOP);

  // RULE_06: Direct low half or indirect.
  // RULE_07: Direct upper half is special space.
  // RULE_08: Auxiliary RAM by external moves.
  // RULE_14: Index moves stay internal.
  // RULE_15: Pointer below 256 served internally.
  msd_space_t space;
  logic [7:0] intAddr;
  always_comb begin
    space   = SPACE_NONE;
    intAddr = dataReq.addr;
    unique case (dataReq.mode)
      ACC_DIRECT: space = directLow ? SPACE_MAIN_RAM : SPACE_SPECIAL;
      ACC_INDIRECT: begin
        space   = SPACE_MAIN_RAM;
        intAddr = ptrAddr;
      end
      ACC_BIT: begin
        space   = dataReq.addr[7] ? SPACE_SPECIAL : SPACE_MAIN_RAM;
        intAddr = bitByte;
      end
      // RULE_12: Stack in main RAM.
      ACC_STACK: begin
        space   = SPACE_MAIN_RAM;
        intAddr = stackPointer;
      end
      ACC_XMOVE_IDX: begin
        space   = SPACE_AUX_RAM;
        intAddr = ptrAddr;
      end
      ACC_XMOVE_PTR: begin
        space   = auxWindow ? SPACE_AUX_RAM : SPACE_EXT_DATA;
        intAddr = dataReq.dataPointer[7:0];
      end
      default: space = SPACE_NONE;
    endcase
  end

  wire logic       dataTake  = idle && dataReq.valid;
  wire logic       fetchTake = idle && fetchReq.valid && !dataTake;
  wire logic       isBit     = (dataReq.mode == ACC_BIT);
  wire logic [2:0] bitIdx    = dataReq.addr[2:0];
  wire logic [7:0] mainByte  = mainRam[intAddr];
  wire logic [7:0] auxByte   = auxRam[intAddr];
  wire logic [7:0] mainWrite = isBit ? set_bit(mainByte, bitIdx, dataReq.wbit) : dataReq.wdata;

  // RULE_01: Internal window when strap high.
  // RULE_02: Strap low forces external.
  wire logic fetchInRange = strapLatchedReg && (fetchReq.addr <= `MSD_INT_PROG_TOP);
  // RULE_04: No switch from external code.
  // RULE_05: Security bit gates blocking.
  wire logic codeBlocked  = fetchReq.codeRead && fetchInRange && !execIntReg && securityBit;
  wire logic fetchInt     = fetchInRange && !codeBlocked;

  wire logic extData  = dataTake && (space == SPACE_EXT_DATA);
  wire logic extFetch = fetchTake && !fetchInt;
  wire logic sfrTake  = dataTake && (space == SPACE_SPECIAL);

  always_comb begin
    stateNext = state;
    unique case (state)
      ST_IDLE: begin
        if (sfrTake) begin
          stateNext = ST_SFR;
        end else if (extData || extFetch) begin
          stateNext = ST_EXT;
        end
      end
      ST_SFR: stateNext = ST_IDLE;
      ST_EXT: if (busDone) begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  // RULE_03: Strap caught only in reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strapLatchedReg <= accessSourceSelect;
      execIntReg      <= accessSourceSelect;
    end else if (fetchTake && !fetchReq.codeRead) begin
      execIntReg <= fetchInt;
    end
  end

  // RULE_09: Aux RAM stays off the pins.
  always_ff @(posedge clk) begin
    if (dataTake && dataReq.write && (space == SPACE_MAIN_RAM)) begin
      mainRam[intAddr] <= mainWrite;
    end
    if (dataTake && dataReq.write && (space == SPACE_AUX_RAM)) begin
      auxRam[intAddr] <= dataReq.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state          <= ST_IDLE;
      fetchReady     <= 1'b0;
      dataReady      <= 1'b0;
      fetchRsp       <= '0;
      dataRsp        <= '0;
      sfrReq         <= '0;
      busReq         <= '0;
      extIsFetchReg  <= 1'b0;
      extCodeReadReg <= 1'b0;
      extAddrReg     <= `MSD_WORD_ZERO;
      sfrBitReg      <= 1'b0;
      sfrBitIdxReg   <= `MSD_CNT_ZERO;
    end else begin
      state          <= stateNext;
      fetchReady     <= (stateNext == ST_IDLE);
      dataReady      <= (stateNext == ST_IDLE);
      fetchRsp.valid <= 1'b0;
      dataRsp.valid  <= 1'b0;
      sfrReq.valid   <= 1'b0;
      busReq.valid   <= 1'b0;
      if (dataTake && (space == SPACE_MAIN_RAM || space == SPACE_AUX_RAM)) begin
        dataRsp.valid <= 1'b1;
        dataRsp.space <= space;
        dataRsp.rdata <= (space == SPACE_AUX_RAM) ? auxByte : mainByte;
        dataRsp.rbit  <= mainByte[bitIdx];
      end
      if (sfrTake) begin
        sfrReq       <= '{valid: 1'b1, write: dataReq.write, bitOp: isBit, addr: intAddr,
                          bitIdx: bitIdx, wdata: dataReq.wdata, wbit: dataReq.wbit};
        sfrBitReg    <= isBit;
        sfrBitIdxReg <= bitIdx;
      end
      if (state == ST_SFR) begin
        dataRsp.valid <= 1'b1;
        dataRsp.space <= SPACE_SPECIAL;
        dataRsp.rdata <= sfrRdata;
        dataRsp.rbit  <= sfrBitReg && sfrRdata[sfrBitIdxReg];
      end
      if (fetchTake && fetchInt) begin
        fetchRsp <= '{valid: 1'b1, internal: 1'b1, blocked: 1'b0, addr: fetchReq.addr,
                      extData: `MSD_BYTE_ZERO};
      end
      // RULE_13: Pointer moves above 255.
      if (extData) begin
        busReq        <= '{valid: 1'b1, kind: dataReq.write ? BUS_WRITE : BUS_READ,
                           addr: dataReq.dataPointer, wdata: dataReq.wdata};
        extIsFetchReg <= 1'b0;
      end else if (extFetch) begin
        busReq         <= '{valid: 1'b1, kind: BUS_FETCH, addr: fetchReq.addr,
                            wdata: `MSD_BYTE_ZERO};
        extIsFetchReg  <= 1'b1;
        extCodeReadReg <= codeBlocked;
        extAddrReg     <= fetchReq.addr;
      end
      if (state == ST_EXT && busDone) begin
        if (extIsFetchReg) begin
          fetchRsp <= '{valid: 1'b1, internal: 1'b0, blocked: extCodeReadReg,
                        addr: extAddrReg, extData: busRdata};
        end else begin
          dataRsp.valid <= 1'b1;
          dataRsp.space <= SPACE_EXT_DATA;
          dataRsp.rdata <= busRdata;
          dataRsp.rbit  <= 1'b0;
        end
      end
    end
  end

  msd_ext_bus msd_ext_bus_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .req       (busReq),
    .done      (busDone),
    .rdata     (busRdata),
    .lowPortIn (lowPortIn),
    .pins      (busPins)
  );

endmodule // memory_space_decoder

`default_nettype wire

// ==== verification/msd_checker_properties.sv ====
// Concurrent checks on the ports of the memory space decoder.
`timescale 1ns/1ps
`default_nettype none
module msd_checker
  import msd_pkg::*;
(
  // Clock and reset
  input wire logic           clk,
  input wire logic           rst_n,
  // Watched ports
  input wire logic           accessSourceSelect,
  input wire msd_fetch_req_t fetchReq,
  input wire logic           fetchReady,
  input wire msd_fetch_rsp_t fetchRsp,
  input wire msd_data_req_t  dataReq,
  input wire logic           dataReady,
  input wire msd_data_rsp_t  dataRsp,
  input wire msd_sfr_req_t   sfrReq,
  input wire msd_pins_t      busPins
);
  logic        strapHeld_reg;
  logic [15:0] ptrHeld_reg;
  logic        dTake;
  logic        fTake;
  assign dTake = dataReady && dataReq.valid;
  assign fTake = fetchReady && fetchReq.valid && !dataReq.valid && !fetchReq.codeRead;
  always_ff @(posedge clk) begin
    if (!rst_n) strapHeld_reg <= accessSourceSelect;
    if (dTake) ptrHeld_reg <= dataReq.dataPointer;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_INT_FETCH: assert property (
    fTake && strapHeld_reg && fetchReq.addr <= 16'h3fff |=> fetchRsp.valid && fetchRsp.internal)
    else $error("internal fetch not served internally");
  AST_EXT_FETCH: assert property (
    fTake && (!strapHeld_reg || fetchReq.addr > 16'h3fff) |-> ##[2:3] !busPins.progStrobe_n
    ##[3:4] (fetchRsp.valid && !fetchRsp.internal)) else $error("external fetch not on bus");
  AST_MAIN_DIRECT: assert property (
    dTake && dataReq.mode == ACC_DIRECT && !dataReq.addr[7] |=> dataRsp.valid
    && dataRsp.space == SPACE_MAIN_RAM && !sfrReq.valid) else $error("direct low not main");
  AST_SPECIAL: assert property (
    dTake && dataReq.mode == ACC_DIRECT && dataReq.addr[7] |=> sfrReq.valid
    && sfrReq.addr == $past(dataReq.addr) ##1 (dataRsp.valid && dataRsp.space == SPACE_SPECIAL))
    else $error("direct high not special");
  AST_AUX_QUIET: assert property (
    dTake && (dataReq.mode == ACC_XMOVE_IDX || (dataReq.mode == ACC_XMOVE_PTR
    && dataReq.dataPointer <= 16'h00ff)) |=> dataRsp.valid && dataRsp.space == SPACE_AUX_RAM
    && $stable(busPins) ##1 $stable(busPins)) else $error("aux access disturbed bus");
  AST_EXT_ADDR: assert property (
    dTake && dataReq.mode == ACC_XMOVE_PTR && dataReq.dataPointer > 16'h00ff |-> ##[1:2]
    (busPins.addrLatch && busPins.lowOe && busPins.highOe && busPins.lowOut == ptrHeld_reg[7:0]
    && busPins.highOut == ptrHeld_reg[15:8])) else $error("external address phase wrong");
  AST_STROBE_AFTER_LATCH: assert property (
    $fell(busPins.rdStrobe_n) || $fell(busPins.wrStrobe_n) |-> $past(busPins.addrLatch))
    else $error("strobe without address latch");
  AST_RD_WIDTH: assert property (
    $fell(busPins.rdStrobe_n) |-> !busPins.rdStrobe_n [*3] ##1 busPins.rdStrobe_n)
    else $error("read strobe width wrong");
  AST_WR_WIDTH: assert property (
    $fell(busPins.wrStrobe_n) |-> !busPins.wrStrobe_n [*3] ##1 busPins.wrStrobe_n)
    else $error("write strobe width wrong");
  AST_PORT_DIR: assert property (
    !busPins.rdStrobe_n || !busPins.wrStrobe_n |-> busPins.highOe
    && busPins.lowOe == !busPins.wrStrobe_n) else $error("port drive wrong in strobe");
endmodule // msd_checker

bind memory_space_decoder msd_checker msd_checker_inst (.clk(clk), .rst_n(rst_n),
  .accessSourceSelect(accessSourceSelect), .fetchReq(fetchReq), .fetchReady(fetchReady),
  .fetchRsp(fetchRsp), .dataReq(dataReq), .dataReady(dataReady), .dataRsp(dataRsp),
  .sfrReq(sfrReq), .busPins(busPins));
`default_nettype wire

// ==== verification/msd_ext_memory.sv ====
// External program and data memory on the expansion bus.
`timescale 1ns/1ps
`default_nettype none
module msd_ext_memory
  import msd_pkg::*;
(
  // Clock
  input wire logic       clk,
  // Expansion pins
  input wire msd_pins_t  pins,
  output logic [7:0]     lowPortIn
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addrHeld_reg;
  logic [7:0]  lastLevel_reg;
  logic        readActive;
  initial begin
    lastLevel_reg = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
  end
  assign readActive = !pins.rdStrobe_n || !pins.progStrobe_n;
  // Released port shows a changing level, never the last byte.
  assign lowPortIn = readActive ? mem[addrHeld_reg] : (pins.lowOe ? pins.lowOut : ~lastLevel_reg);
  always @(posedge clk) begin
    lastLevel_reg <= lowPortIn;
    if (pins.addrLatch) addrHeld_reg <= {pins.highOut, pins.lowOut};
    if (!pins.wrStrobe_n && pins.lowOe) mem[addrHeld_reg] <= pins.lowOut;
  end
endmodule // msd_ext_memory
`default_nettype wire

// ==== verification/memory_space_decoder_tb.sv ====
// Self-checking testbench of the memory space decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", w, e, g); end end
module memory_space_decoder_tb
  import msd_pkg::*;
;
  logic           clk;
  logic           rst_n;
  logic           strap;
  logic           secure;
  logic [1:0]     bankSel;
  logic [7:0]     sp;
  logic [7:0]     lowPortIn;
  logic           fetchReady;
  logic           dataReady;
  msd_fetch_req_t fetchReq;
  msd_fetch_rsp_t fetchRsp;
  msd_fetch_rsp_t fr;
  msd_data_req_t  dataReq;
  msd_data_rsp_t  dataRsp;
  msd_data_rsp_t  dr;
  msd_sfr_req_t   sfrReq;
  msd_sfr_req_t   sq;
  msd_pins_t      busPins;
  int             miscompares;
  int             totalChecks;
  memory_space_decoder memory_space_decoder_inst (.clk(clk), .rst_n(rst_n),
    .accessSourceSelect(strap), .securityBit(secure), .bankSel(bankSel), .stackPointer(sp),
    .fetchReq(fetchReq), .fetchReady(fetchReady), .fetchRsp(fetchRsp), .dataReq(dataReq),
    .dataReady(dataReady), .dataRsp(dataRsp), .sfrReq(sfrReq), .sfrRdata(8'h3c),
    .lowPortIn(lowPortIn), .busPins(busPins));
  msd_ext_memory msd_ext_memory_inst (.clk(clk), .pins(busPins), .lowPortIn(lowPortIn));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reset_dut(input logic s);
    rst_n = 1'b0;
    strap = s;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    strap = ~s;
    repeat (2) @(negedge clk);
  endtask
  task automatic fetch(input logic [15:0] a, input logic code);
    int i;
    for (i = 0; i < 20 && fetchReady !== 1'b1; i++) @(negedge clk);
    fetchReq = '{valid: 1'b1, codeRead: code, addr: a};
    @(negedge clk);
    fetchReq.valid = 1'b0;
    for (i = 0; i < 20 && fetchRsp.valid !== 1'b1; i++) @(negedge clk);
    fr = fetchRsp;
    if (i == 20) begin
      miscompares++;
      $display("Error fetch answer expected 1 seen 0");
    end
  endtask
  task automatic access(input msd_mode_t m, input logic w, input logic x, input logic [7:0] a,
                        input logic [15:0] dp, input logic [7:0] wd);
    int i;
    for (i = 0; i < 20 && dataReady !== 1'b1; i++) @(negedge clk);
    dataReq = '{valid: 1'b1, mode: m, write: w, idxSel: x, addr: a, dataPointer: dp,
                wdata: wd, wbit: wd[0]};
    @(negedge clk);
    dataReq.valid = 1'b0;
    sq = sfrReq;
    for (i = 0; i < 20 && dataRsp.valid !== 1'b1; i++) @(negedge clk);
    dr = dataRsp;
    if (i == 20) begin
      miscompares++;
      $display("Error data answer expected 1 seen 0");
    end
  endtask
  task automatic test_fetch_map();
    fetch(16'h3fff, 1'b0);
    `CHK("internal", 1'b1, fr.internal)
    fetch(16'h4000, 1'b0);
    `CHK("internal", 1'b0, fr.internal)
    `CHK("ext byte", 8'h40, fr.extData)
    `CHK("fetch addr", 16'h4000, fr.addr)
    fetch(16'hfffe, 1'b0);
    `CHK("ext byte", 8'h01, fr.extData)
    $display("test fetch_map done");
  endtask
  task automatic test_code_protect();
    secure = 1'b1;
    fetch(16'h0123, 1'b1);
    `CHK("internal", 1'b0, fr.internal)
    `CHK("blocked", 1'b1, fr.blocked)
    `CHK("ext byte", 8'h22, fr.extData)
    secure = 1'b0;
    fetch(16'h0123, 1'b1);
    `CHK("internal", 1'b1, fr.internal)
    `CHK("blocked", 1'b0, fr.blocked)
    fetch(16'h0000, 1'b0);
    `CHK("internal", 1'b1, fr.internal)
    $display("test code_protect done");
  endtask
  task automatic test_strap_low();
    reset_dut(1'b0);
    fetch(16'h0000, 1'b0);
    `CHK("internal", 1'b0, fr.internal)
    fetch(16'h3fff, 1'b0);
    `CHK("internal", 1'b0, fr.internal)
    `CHK("ext byte", 8'hc0, fr.extData)
    reset_dut(1'b1);
    $display("test strap_low done");
  endtask
  task automatic test_ram_banks();
    for (int b = 0; b < 4; b++) begin
      bankSel = 2'(b);
      access(ACC_DIRECT, 1'b1, 1'b0, {3'h0, 2'(b), 3'h1}, 16'h0000, 8'hc0 + 8'(b));
      access(ACC_INDIRECT, 1'b1, 1'b1, 8'h00, 16'h0000, 8'ha0 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      bankSel = 2'(b);
      access(ACC_INDIRECT, 1'b0, 1'b1, 8'h00, 16'h0000, 8'h00);
      `CHK("bank data", 8'ha0 + 8'(b), dr.rdata)
      `CHK("space", SPACE_MAIN_RAM, dr.space)
    end
    access(ACC_DIRECT, 1'b0, 1'b0, 8'h09, 16'h0000, 8'h00);
    `CHK("bank reg", 8'hc1, dr.rdata)
    $display("test ram_banks done");
  endtask
  task automatic test_special();
    access(ACC_DIRECT, 1'b0, 1'b0, 8'h90, 16'h0000, 8'h00);
    `CHK("space", SPACE_SPECIAL, dr.space)
    `CHK("sfr data", 8'h3c, dr.rdata)
    access(ACC_BIT, 1'b0, 1'b0, 8'h95, 16'h0000, 8'h00);
    `CHK("sfr bit", 1'b1, dr.rbit)
    `CHK("sfr addr", 8'h90, sq.addr)
    `CHK("sfr bitop", 1'b1, sq.bitOp)
    `CHK("sfr bit index", 3'h5, sq.bitIdx)
    access(ACC_BIT, 1'b0, 1'b0, 8'h96, 16'h0000, 8'h00);
    `CHK("sfr bit", 1'b0, dr.rbit)
    access(ACC_DIRECT, 1'b1, 1'b0, 8'h7f, 16'h0000, 8'h5e);
    access(ACC_DIRECT, 1'b0, 1'b0, 8'h7f, 16'h0000, 8'h00);
    `CHK("space", SPACE_MAIN_RAM, dr.space)
    `CHK("main data", 8'h5e, dr.rdata)
    $display("test special done");
  endtask
  task automatic test_bits_stack();
    access(ACC_DIRECT, 1'b1, 1'b0, 8'h2f, 16'h0000, 8'h00);
    access(ACC_BIT, 1'b1, 1'b0, 8'h7f, 16'h0000, 8'h01);
    access(ACC_DIRECT, 1'b0, 1'b0, 8'h2f, 16'h0000, 8'h00);
    `CHK("bit byte", 8'h80, dr.rdata)
    access(ACC_BIT, 1'b0, 1'b0, 8'h7f, 16'h0000, 8'h00);
    `CHK("bit", 1'b1, dr.rbit)
    sp = 8'hf7;
    access(ACC_STACK, 1'b1, 1'b0, 8'h00, 16'h0000, 8'h77);
    bankSel = 2'h0;
    access(ACC_DIRECT, 1'b1, 1'b0, 8'h00, 16'h0000, 8'hf7);
    access(ACC_INDIRECT, 1'b0, 1'b0, 8'h00, 16'h0000, 8'h00);
    `CHK("stack data", 8'h77, dr.rdata)
    $display("test bits_stack done");
  endtask
  task automatic test_external_data();
    access(ACC_XMOVE_PTR, 1'b1, 1'b0, 8'h00, 16'h00ff, 8'h11);
    `CHK("space", SPACE_AUX_RAM, dr.space)
    access(ACC_XMOVE_PTR, 1'b1, 1'b0, 8'h00, 16'h12ff, 8'h99);
    `CHK("space", SPACE_EXT_DATA, dr.space)
    access(ACC_DIRECT, 1'b1, 1'b0, 8'h01, 16'h0000, 8'hff);
    access(ACC_XMOVE_IDX, 1'b0, 1'b1, 8'h00, 16'h12ff, 8'h00);
    `CHK("aux data", 8'h11, dr.rdata)
    `CHK("space", SPACE_AUX_RAM, dr.space)
    access(ACC_XMOVE_PTR, 1'b0, 1'b0, 8'h00, 16'h12ff, 8'h00);
    `CHK("ext data", 8'h99, dr.rdata)
    access(ACC_XMOVE_PTR, 1'b0, 1'b0, 8'h00, 16'h0100, 8'h00);
    `CHK("ext data", 8'h01, dr.rdata)
    $display("test external_data done");
  endtask
  initial begin
    #100000;
    miscompares++;
    $display("Error watchdog expected done seen timeout");
    report_and_stop();
  end
  initial begin
    {secure, bankSel, sp, fetchReq, dataReq} = '0;
    reset_dut(1'b1);
    test_fetch_map();
    test_code_protect();
    test_strap_low();
    test_ram_banks();
    test_special();
    test_bits_stack();
    test_external_data();
    report_and_stop();
  end
endmodule // memory_space_decoder_tb
`default_nettype wire
